// ==== common/cppc_pkg.sv ====
// constants and types for the configuration port pin control block
// assumes one 250 MHz core clock; all pins arrive synchronous or via sync
package cppc_pkg;
  // mode codes on the four mode inputs
  localparam logic [3:0] MODE_ASYNC_PERIPH = 4'h5;
  localparam logic [3:0] MODE_MASTER_PAR   = 4'h4;
  localparam logic [3:0] MODE_PORT         = 4'h7;
  localparam logic [3:0] MODE_RESET        = 4'hF;
  // transfer size codes
  localparam logic [1:0] TSZ_WORD = 2'h0;
  localparam logic [1:0] TSZ_BYTE = 2'h1;
  localparam logic [1:0] TSZ_HALF = 2'h2;
  // field widths and positions
  localparam int ADDR_W     = 18;
  localparam int DATA_W     = 8;
  localparam int STAT_W     = 4;
  localparam int RDY_BIT    = 7;
  localparam int STAT_LO    = 3;
  localparam int SYNC_W     = 2;
  // memory read clock half period in core cycles
  localparam int RCLK_HALF  = 4;
  localparam int RCLK_CNT_W = 3;
  typedef enum logic [2:0] {
    CPPC_POWER,
    CPPC_CLEAR,
    CPPC_WAIT,
    CPPC_LOAD,
    CPPC_DONE
  } cppc_state_e;
endpackage

// ==== design/cppc_strobe_sync.sv ====
// two-stage synchroniser with falling-edge detect for active-low strobes
// assumes strobes idle high; reset state matches idle
`timescale 1ns/1ps
module cppc_strobe_sync #(
  parameter int W = 2
) (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  // raw strobes
  input  wire logic [W-1:0] strobe_n,
  // synchronised level and one-cycle fall pulse
  output logic      [W-1:0] level_n,
  output logic      [W-1:0] fall
);
  logic [W-1:0] meta;
  logic [W-1:0] prev;

  // first stage feeds only the second
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta    <= '1;
      level_n <= '1;
      prev    <= '1;
    end else begin
      meta    <= strobe_n;
      level_n <= meta;
      prev    <= level_n;
    end
  end

  assign fall = prev & ~level_n;
endmodule

// ==== design/cppc_pin_ctrl.sv ====
// configuration pin control: mode latch, status pins, init handshake,
// asynchronous peripheral byte load and processor port pin handling
// assumes the core supplies supply, clearing and finish levels
//
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/1ps
module cppc_pin_ctrl (
  // clock and reset
  input  wire logic                         core_clk,
  input  wire logic                         rst_n,
  // mode and init pins
  input  wire logic [3:0]                   mode_select,
  input  wire logic                         init_in,
  output logic                              init_out,
  output logic                              init_oe_n,
  // status pins
  output logic                              configuring_high_flag,
  output logic                              configuring_low_flag,
  output logic                              done_out,
  output logic                              done_oe_n,
  output logic                              ready_out,
  output logic                              ready_oe_n,
  // select and strobes
  input  wire logic                         chip_select_low_active,
  input  wire logic                         chip_select_high_active,
  input  wire logic                         rd_strobe_n,
  input  wire logic                         wr_strobe_n,
  // data bus
  input  wire logic [cppc_pkg::DATA_W-1:0]  data_in,
  output logic      [cppc_pkg::DATA_W-1:0]  data_out,
  output logic      [cppc_pkg::DATA_W-1:0]  data_oe_n,
  // processor port pins
  input  wire logic [cppc_pkg::ADDR_W-1:0]  host_address,
  input  wire logic                         host_burst_n,
  input  wire logic [1:0]                   host_transfer_size,
  output logic                              host_acknowledge_n,
  output logic                              ack_oe_n,
  // core status and options
  input  wire logic                         power_stable,
  input  wire logic                         memory_cleared,
  input  wire logic                         config_finished,
  input  wire logic                         boundary_scan_sel,
  input  wire logic                         processor_port_used,
  input  wire logic [cppc_pkg::STAT_W-1:0]  core_status,
  output logic      [3:0]                   mode_latched,
  output logic                              boundary_scan_active,
  output logic                              user_io_released,
  // configuration byte stream
  output logic      [cppc_pkg::DATA_W-1:0]  cfg_byte,
  output logic                              cfg_byte_valid,
  input  wire logic                         cfg_byte_taken,
  // processor port core side
  input  wire logic [cppc_pkg::DATA_W-1:0]  port_rd_data,
  output logic      [cppc_pkg::ADDR_W-1:0]  port_addr,
  output logic      [1:0]                   port_size,
  output logic                              port_burst,
  output logic      [cppc_pkg::DATA_W-1:0]  port_wr_data,
  output logic                              port_wr,
  output logic                              port_rd
);

  cppc_pkg::cppc_state_e st;
  logic                              init_q;
  logic                              busy;
  logic                              selected;
  logic                              rd_lvl_n;
  logic                              wr_lvl_n;
  logic                              rd_fall;
  logic                              wr_fall;
  logic [cppc_pkg::SYNC_W-1:0]       lvl_n;
  logic [cppc_pkg::SYNC_W-1:0]       falls;
  logic                              periph_mode;
  logic                              port_mode;
  logic                              rd_fetch;
  logic                              port_hold;
  logic [cppc_pkg::RCLK_CNT_W-1:0]   rclk_cnt;
  logic                              rclk;

  function automatic logic is_selected(input logic cs_lo, input logic cs_hi);
    return !cs_lo && cs_hi;
  endfunction

  // strobes cross in through a two-stage synchroniser
  cppc_strobe_sync #(
    .W (cppc_pkg::SYNC_W)
  ) u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .strobe_n ({wr_strobe_n, rd_strobe_n}),
    .level_n  (lvl_n),
    .fall     (falls)
  );

  assign rd_lvl_n = lvl_n[0];
  assign wr_lvl_n = lvl_n[1];
  assign rd_fall  = falls[0];
  assign wr_fall  = falls[1];
  assign selected = is_selected(chip_select_low_active, chip_select_high_active);
  assign periph_mode = (st == cppc_pkg::CPPC_LOAD)
                    && (mode_latched == cppc_pkg::MODE_ASYNC_PERIPH);
  // port stays live after loading when the port is in use
  assign port_mode = ((st == cppc_pkg::CPPC_LOAD)
                    && (mode_latched == cppc_pkg::MODE_PORT))
                  || ((st == cppc_pkg::CPPC_DONE) && processor_port_used);

  // sequence: supply settle, clearing, wait, load, done
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= cppc_pkg::CPPC_POWER;
    end else begin
      unique case (st)
        cppc_pkg::CPPC_POWER: begin
          if (power_stable) begin
            st <= cppc_pkg::CPPC_CLEAR;
          end
        end
        cppc_pkg::CPPC_CLEAR: begin
          if (memory_cleared) begin
            st <= cppc_pkg::CPPC_WAIT;
          end
        end
        cppc_pkg::CPPC_WAIT: begin
          if (init_in && !init_q) begin
            st <= cppc_pkg::CPPC_LOAD;
          end
        end
        cppc_pkg::CPPC_LOAD: begin
          if (config_finished) begin
            st <= cppc_pkg::CPPC_DONE;
          end
        end
        cppc_pkg::CPPC_DONE: begin
          st <= cppc_pkg::CPPC_DONE;
        end
      endcase
    end
  end

  // mode taken on the init rising edge only
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      init_q       <= 1'b0;
      mode_latched <= cppc_pkg::MODE_RESET;
    end else begin
      init_q <= init_in;
      if (st == cppc_pkg::CPPC_WAIT && init_in && !init_q) begin
        mode_latched <= mode_select;
      end
    end
  end

  // init pin: open drain, driven low while settling and clearing
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      init_out  <= 1'b0;
      init_oe_n <= 1'b0;
    end else begin
      init_out  <= 1'b0;
      init_oe_n <= !(st == cppc_pkg::CPPC_POWER || st == cppc_pkg::CPPC_CLEAR);
    end
  end

  // status pins follow the done state
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      configuring_high_flag <= 1'b1;
      configuring_low_flag  <= 1'b0;
      done_out              <= 1'b0;
      done_oe_n             <= 1'b0;
      boundary_scan_active  <= 1'b1;
      user_io_released      <= 1'b0;
    end else begin
      configuring_high_flag <= (st != cppc_pkg::CPPC_DONE);
      configuring_low_flag  <= (st == cppc_pkg::CPPC_DONE);
      done_out              <= 1'b0;
      done_oe_n             <= (st == cppc_pkg::CPPC_DONE);
      boundary_scan_active  <= (st != cppc_pkg::CPPC_DONE) || boundary_scan_sel;
      user_io_released      <= (st == cppc_pkg::CPPC_DONE) && !processor_port_used;
    end
  end

  // byte capture; a busy device ignores further writes until taken
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_byte       <= '0;
      cfg_byte_valid <= 1'b0;
      busy           <= 1'b0;
    end else begin
      cfg_byte_valid <= 1'b0;
      if (periph_mode && selected && wr_fall && !busy) begin
        cfg_byte       <= data_in;
        cfg_byte_valid <= 1'b1;
        busy           <= 1'b1;
      end else if (cfg_byte_taken) begin
        busy <= 1'b0;
      end
    end
  end

  // memory read clock for master parallel loading
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rclk_cnt <= '0;
      rclk     <= 1'b0;
    end else if (st == cppc_pkg::CPPC_LOAD
              && mode_latched == cppc_pkg::MODE_MASTER_PAR) begin
      if (rclk_cnt == cppc_pkg::RCLK_CNT_W'(cppc_pkg::RCLK_HALF - 1)) begin
        rclk_cnt <= '0;
        rclk     <= !rclk;
      end else begin
        rclk_cnt <= rclk_cnt + 1'b1;
      end
    end else begin
      rclk_cnt <= '0;
      rclk     <= 1'b0;
    end
  end

  // ready pin: busy status or read clock, else released
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ready_out  <= 1'b0;
      ready_oe_n <= 1'b1;
    end else if (periph_mode) begin
      ready_out  <= !busy;
      ready_oe_n <= 1'b0;
    end else if (st == cppc_pkg::CPPC_LOAD
              && mode_latched == cppc_pkg::MODE_MASTER_PAR) begin
      ready_out  <= rclk;
      ready_oe_n <= 1'b0;
    end else begin
      ready_out  <= 1'b0;
      ready_oe_n <= 1'b1;
    end
  end

  // processor port transfer; one request per read strobe fall
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_addr    <= '0;
      port_size    <= cppc_pkg::TSZ_WORD;
      port_burst   <= 1'b0;
      port_wr_data <= '0;
      port_wr      <= 1'b0;
      port_rd      <= 1'b0;
      rd_fetch     <= 1'b0;
      port_hold    <= 1'b0;
    end else begin
      port_wr  <= 1'b0;
      port_rd  <= 1'b0;
      rd_fetch <= port_rd;
      if (port_mode && selected && rd_fall) begin
        port_addr  <= host_address;
        port_size  <= host_transfer_size;
        port_burst <= !host_burst_n;
        port_hold  <= 1'b1;
        if (wr_lvl_n) begin
          port_rd <= 1'b1;
        end else begin
          port_wr      <= 1'b1;
          port_wr_data <= data_in;
        end
      end else if (rd_lvl_n) begin
        port_hold <= 1'b0;
      end
    end
  end

  // acknowledge low from data taken or given until the strobe ends
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      host_acknowledge_n <= 1'b1;
      ack_oe_n           <= 1'b1;
    end else begin
      ack_oe_n <= !port_mode;
      if (port_wr || rd_fetch) begin
        host_acknowledge_n <= 1'b0;
      end else if (!port_hold || rd_lvl_n) begin
        host_acknowledge_n <= 1'b1;
      end
    end
  end

  // data bus drive: port read data or peripheral status
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_out  <= '0;
      data_oe_n <= '1;
    end else if (port_mode && port_hold && wr_lvl_n && !rd_lvl_n) begin
      if (rd_fetch) begin
        data_out  <= port_rd_data;
        data_oe_n <= '0;
      end
    end else if (periph_mode && selected && !rd_lvl_n && wr_lvl_n) begin
      // a low write strobe wins, so status is only shown with it high
      data_out  <= {!busy, core_status, 3'h0};
      data_oe_n <= {5'h00, 3'h7};
    end else begin
      data_out  <= '0;
      data_oe_n <= '1;
    end
  end

  AST_MODE_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
    (st == cppc_pkg::CPPC_LOAD) |=> $stable(mode_latched))
    else $error("mode changed after latch");

  AST_FLAG_PAIR: assert property (@(posedge core_clk) disable iff (!rst_n)
    configuring_low_flag != configuring_high_flag)
    else $error("status flags not complementary");

  AST_HIGH_FLAG: assert property (@(posedge core_clk) disable iff (!rst_n)
    (st == cppc_pkg::CPPC_LOAD) |=> configuring_high_flag)
    else $error("high flag dropped while loading");

  AST_INIT_LOW: assert property (@(posedge core_clk) disable iff (!rst_n)
    (st == cppc_pkg::CPPC_CLEAR) |=> (!init_oe_n && !init_out))
    else $error("init not held low while clearing");

  AST_WAIT_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
    (st == cppc_pkg::CPPC_WAIT && !init_in) |=> (st == cppc_pkg::CPPC_WAIT))
    else $error("left wait while init held low");

  AST_SELECT: assert property (@(posedge core_clk) disable iff (!rst_n)
    cfg_byte_valid |-> $past(selected))
    else $error("byte captured while not selected");

  AST_READY: assert property (@(posedge core_clk) disable iff (!rst_n)
    (periph_mode && cfg_byte_valid) |=> !ready_out)
    else $error("ready high after capture");

  AST_STATUS_D7: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!data_oe_n[cppc_pkg::RDY_BIT] && !ready_oe_n && periph_mode)
      |-> (data_out[cppc_pkg::RDY_BIT] == ready_out))
    else $error("bit 7 differs from ready");

  AST_WR_WINS: assert property (@(posedge core_clk) disable iff (!rst_n)
    (periph_mode && !wr_lvl_n) |=> data_oe_n[cppc_pkg::STAT_LO])
    else $error("status driven during write");

  AST_ONCE: assert property (@(posedge core_clk) disable iff (!rst_n)
    cfg_byte_valid |=> !cfg_byte_valid)
    else $error("one strobe captured twice");

  AST_ACK: assert property (@(posedge core_clk) disable iff (!rst_n)
    port_wr |=> !host_acknowledge_n)
    else $error("no acknowledge after write");

  AST_DONE_REL: assert property (@(posedge core_clk) disable iff (!rst_n)
    (st == cppc_pkg::CPPC_DONE) |=> (done_oe_n && !configuring_high_flag))
    else $error("done not released");

  AST_BSCAN: assert property (@(posedge core_clk) disable iff (!rst_n)
    (st == cppc_pkg::CPPC_DONE && !boundary_scan_sel) |=> !boundary_scan_active)
    else $error("scan still active");

  AST_RELEASE: assert property (@(posedge core_clk) disable iff (!rst_n)
    processor_port_used |=> !user_io_released)
    else $error("port pins released while used");

endmodule

// ==== verification/cppc_host_model.sv ====
// host side of the configuration pins: select, strobes, data, port fields
// assumes pull-ups on init and data lines; strobes change after rising edge
`timescale 1ns/1ps
module cppc_host_model (
  // clock
  input  wire logic        core_clk,
  // from the device
  input  wire logic        init_oe_n,
  input  wire logic [7:0]  data_out,
  input  wire logic [7:0]  data_oe_n,
  input  wire logic        host_acknowledge_n,
  // toward the device
  output logic             init_in,
  output logic [7:0]       data_in,
  output logic             chip_select_low_active,
  output logic             chip_select_high_active,
  output logic             rd_strobe_n,
  output logic             wr_strobe_n,
  output logic [17:0]      host_address,
  output logic             host_burst_n,
  output logic [1:0]       host_transfer_size,
  output logic             test_mode_sel
);
  logic       init_hold = 1'b0;
  logic       drv = 1'b0;
  logic [7:0] dq = 8'h00;
  logic [7:0] seen;
  logic [7:0] oe_seen;
  logic [7:0] ack_data;
  logic       ack_seen;
  initial begin
    chip_select_low_active = 1'b1;
    chip_select_high_active = 1'b0;
    rd_strobe_n = 1'b1;
    wr_strobe_n = 1'b1;
    host_address = 18'h0_0000;
    host_burst_n = 1'b1;
    host_transfer_size = 2'h0;
  end
  // pulled up; holding it low keeps the device waiting
  assign init_in = init_oe_n & ~init_hold;
  assign test_mode_sel = 1'b1;
  // released bits float to the pull-up, never to the last value
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      data_in[i] = !data_oe_n[i] ? data_out[i] : (drv ? dq[i] : 1'b1);
    end
  end
  task automatic set_port(input logic [17:0] a, input logic [1:0] sz, input logic burst);
    @(posedge core_clk);
    host_address <= a;
    host_transfer_size <= sz;
    host_burst_n <= ~burst;
  endtask
  // one strobe pulse held for hold cycles; wr also drives the data
  task automatic cycle(input logic rd, input logic wr, input logic sel,
                       input logic [7:0] d, input int hold);
    @(posedge core_clk);
    chip_select_low_active <= ~sel;
    chip_select_high_active <= sel;
    rd_strobe_n <= ~rd;
    wr_strobe_n <= ~wr;
    drv <= wr;
    dq <= d;
    ack_seen = 1'b0;
    repeat (hold) begin
      @(negedge core_clk);
      seen = data_in;
      oe_seen = data_oe_n;
      if (host_acknowledge_n === 1'b0 && !ack_seen) begin
        ack_seen = 1'b1;
        ack_data = data_in;
      end
      @(posedge core_clk);
    end
    rd_strobe_n <= 1'b1;
    wr_strobe_n <= 1'b1;
    chip_select_low_active <= 1'b1;
    chip_select_high_active <= 1'b0;
    drv <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask
endmodule

// ==== verification/cppc_pin_ctrl_tb.sv ====
// self-checking bench for the configuration pin control block
// assumes the host model for the pins; the bench plays the core side
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin failures++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module cppc_pin_ctrl_tb;
  logic core_clk = 1'b0, rst_n = 1'b0, power_stable = 1'b0, memory_cleared = 1'b0;
  logic config_finished = 1'b0, boundary_scan_sel = 1'b0, processor_port_used = 1'b0;
  logic cfg_byte_taken = 1'b0;
  logic init_out, done_out;
  logic [3:0] mode_select = 4'h0, core_status = 4'h0;
  logic [7:0] port_rd_data = 8'h00;
  logic init_in, init_oe_n, configuring_high_flag, configuring_low_flag, done_oe_n;
  logic ready_out, ready_oe_n, chip_select_low_active, chip_select_high_active;
  logic rd_strobe_n, wr_strobe_n, host_burst_n, host_acknowledge_n, ack_oe_n;
  logic boundary_scan_active, user_io_released, cfg_byte_valid, port_burst, port_wr, port_rd;
  logic [7:0] data_in, data_out, data_oe_n, cfg_byte, port_wr_data, last_byte;
  logic [17:0] host_address, port_addr;
  logic [1:0] host_transfer_size, port_size;
  logic [3:0] mode_latched;
  int failures = 0, num_checks = 0, n_valid = 0, n_pwr = 0, n_prd = 0;
  always #2 core_clk = ~core_clk;
  cppc_pin_ctrl dut_u (.core_clk, .rst_n, .mode_select, .init_in, .init_out, .init_oe_n,
    .configuring_high_flag, .configuring_low_flag, .done_out, .done_oe_n, .ready_out,
    .ready_oe_n, .chip_select_low_active, .chip_select_high_active, .rd_strobe_n,
    .wr_strobe_n, .data_in, .data_out, .data_oe_n, .host_address, .host_burst_n,
    .host_transfer_size, .host_acknowledge_n, .ack_oe_n, .power_stable, .memory_cleared,
    .config_finished, .boundary_scan_sel, .processor_port_used, .core_status, .mode_latched,
    .boundary_scan_active, .user_io_released, .cfg_byte, .cfg_byte_valid, .cfg_byte_taken,
    .port_rd_data, .port_addr, .port_size, .port_burst, .port_wr_data, .port_wr, .port_rd);
  cppc_host_model host_u (.core_clk, .init_oe_n, .data_out, .data_oe_n, .host_acknowledge_n,
    .init_in, .data_in, .chip_select_low_active, .chip_select_high_active, .rd_strobe_n,
    .wr_strobe_n, .host_address, .host_burst_n, .host_transfer_size, .test_mode_sel());
  // pulse counters; a doubled pulse shows up as an extra count
  always @(posedge core_clk) begin
    if (cfg_byte_valid === 1'b1) begin
      n_valid++;
      last_byte = cfg_byte;
    end
    if (port_wr === 1'b1) n_pwr++;
    if (port_rd === 1'b1) n_prd++;
  end
  task automatic print_verdict();
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic bring_up(input logic [3:0] mode, input int hold);
    @(posedge core_clk);
    rst_n <= 1'b0;
    {power_stable, memory_cleared, config_finished} <= 3'b000;
    mode_select <= mode;
    host_u.init_hold <= 1'b1;
    repeat (5) @(posedge core_clk);
    @(negedge core_clk);
    `CHK(init_oe_n, 1'b0)
    `CHK({configuring_high_flag, configuring_low_flag}, 2'b10)
    `CHK({done_out, init_out, done_oe_n, ready_oe_n}, 4'b0001)
    @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    power_stable <= 1'b1;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    `CHK(init_oe_n, 1'b0)
    @(posedge core_clk);
    memory_cleared <= 1'b1;
    repeat (4 + hold) @(posedge core_clk);
    @(negedge core_clk);
    `CHK(init_oe_n, 1'b1)
    `CHK({mode_latched, ready_oe_n}, 5'h1F)
    @(posedge core_clk);
    host_u.init_hold <= 1'b0;
    repeat (3) @(posedge core_clk);
    mode_select <= ~mode;
    @(negedge core_clk);
    `CHK(mode_latched, mode)
    `CHK(configuring_high_flag, 1'b1)
  endtask
  task automatic taken();
    @(posedge core_clk);
    cfg_byte_taken <= 1'b1;
    @(posedge core_clk);
    cfg_byte_taken <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic t_periph();
    int nv;
    nv = n_valid;
    @(posedge core_clk);
    core_status <= 4'hA;
    @(negedge core_clk);
    `CHK({ready_oe_n, ready_out}, 2'b01)
    host_u.cycle(1'b0, 1'b1, 1'b1, 8'hA5, 6);
    `CHK(n_valid, nv + 1)
    `CHK(last_byte, 8'hA5)
    `CHK(ready_out, 1'b0)
    host_u.cycle(1'b0, 1'b1, 1'b1, 8'h11, 6);
    host_u.cycle(1'b1, 1'b0, 1'b1, 8'h00, 6);
    `CHK(host_u.seen[7:3], 5'h0A)
    `CHK(host_u.oe_seen, 8'h07)
    taken();
    host_u.cycle(1'b0, 1'b1, 1'b0, 8'h22, 6);
    `CHK(n_valid, nv + 1)
    `CHK(ready_out, 1'b1)
    host_u.cycle(1'b1, 1'b0, 1'b1, 8'h00, 6);
    `CHK(host_u.seen[7], 1'b1)
    host_u.cycle(1'b1, 1'b1, 1'b1, 8'h3C, 6);
    `CHK({last_byte, host_u.oe_seen}, 16'h3CFF)
    `CHK(n_valid, nv + 2)
    taken();
    $display("peripheral load test ended");
  endtask
  task automatic t_port();
    logic [1:0] sz [3] = '{cppc_pkg::TSZ_BYTE, cppc_pkg::TSZ_HALF, cppc_pkg::TSZ_WORD};
    int np;
    processor_port_used <= 1'b1;
    config_finished <= 1'b1;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    `CHK({configuring_high_flag, configuring_low_flag, done_oe_n, done_out}, 4'b0110)
    `CHK({boundary_scan_active, user_io_released, ack_oe_n}, 3'b000)
    for (int i = 0; i < 3; i++) begin
      host_u.set_port(18'h2_A5C0 + 18'(i), sz[i], i == 1);
      np = n_pwr;
      host_u.cycle(1'b1, 1'b1, 1'b1, 8'h5A + 8'(i), 10);
      `CHK(n_pwr, np + 1)
      `CHK(port_wr_data, 8'h5A + 8'(i))
      `CHK(port_addr, 18'h2_A5C0 + 18'(i))
      `CHK({port_size, port_burst}, {sz[i], i == 1})
      `CHK({host_u.ack_seen, host_acknowledge_n}, 2'b11)
    end
    port_rd_data <= 8'hC3;
    np = n_prd;
    host_u.cycle(1'b1, 1'b0, 1'b1, 8'h00, 10);
    `CHK(n_prd, np + 1)
    `CHK(host_u.ack_data, 8'hC3)
    $display("port transfer test ended");
  endtask
  task automatic t_master();
    int hi;
    hi = 0;
    boundary_scan_sel <= 1'b1;
    processor_port_used <= 1'b0;
    bring_up(cppc_pkg::MODE_MASTER_PAR, 2);
    `CHK(ready_oe_n, 1'b0)
    repeat (8) begin
      @(negedge core_clk);
      hi += int'(ready_out === 1'b1);
    end
    `CHK(hi, 4)
    @(posedge core_clk);
    config_finished <= 1'b1;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    `CHK({user_io_released, boundary_scan_active}, 2'b11)
    $display("master parallel test ended");
  endtask
  initial begin
    repeat (100000) @(posedge core_clk);
    failures++;
    print_verdict();
  end
  initial begin
    bring_up(cppc_pkg::MODE_ASYNC_PERIPH, 10);
    t_periph();
    t_port();
    t_master();
    print_verdict();
  end
endmodule
